// file: verilog/sbs_basic_setting.sv
// basic-setting logic: gain mode, response level, in-position, direction, A/B output
// assumes synchronous inputs on clk; encoder steps arrive at most one per clock
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sbs_basic_setting (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    // avalon-mm slave
    input  wire logic [7:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic      [31:0]            avs_readdata,
    output logic                        avs_waitrequest,
    // position loop
    input  wire logic signed [31:0]     pos_err,
    input  wire logic                   addr_inc,
    input  wire logic                   addr_dec,
    output logic                        motor_ccw_step,
    output logic                        motor_cw_step,
    output logic                        in_position_flag,
    // encoder feedback
    input  wire logic                   enc_step,
    input  wire logic                   enc_ccw,
    output logic                        enc_a,
    output logic                        enc_b,
    // tuning engine
    output sbs_pkg::sbs_gain_mode_t     gain_mode,
    output sbs_pkg::sbs_gain_upd_t      gain_upd,
    output logic      [15:0]            tuning_response_level,
    output sbs_pkg::sbs_restart_t       restart_active
);
    import sbs_pkg::*;

    function automatic logic [15:0] be_merge(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [15:0] r;
        r = old;
        if (be[0]) r[7:0]  = wd[7:0];
        if (be[1]) r[15:8] = wd[15:8];
        return r;
    endfunction : be_merge

    function automatic sbs_gain_upd_t upd_decode(input sbs_gain_mode_t m);
        sbs_gain_upd_t u;
        u = '0;
        case (m)
            SBS_GM_INTERP: u = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
            SBS_GM_TUNE1:  u = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
            SBS_GM_TUNE2:  u = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
            default:       u = '0;
        endcase
        return u;
    endfunction : upd_decode

    // register storage
    logic [15:0]   gain_mode_r;
    logic [15:0]   resp_r;
    logic [15:0]   inp_win_r;
    logic [15:0]   dir_r;
    logic [15:0]   enr_r;
    logic [15:0]   pmode_r;
    logic          speed_mode_r;
    sbs_restart_t  act_r;
    logic          crst_r;
    logic          wait_r;
    logic [31:0]   rdata_r;

    // bus decode
    wire           req       = avs_read | avs_write;
    wire           done      = req & ~wait_r;
    wire           wr_do     = avs_write & done;
    wire           sel_gm    = (avs_address == OFS_GAIN_MODE);
    wire           sel_rsp   = (avs_address == OFS_RESP);
    wire           sel_inp   = (avs_address == OFS_INP_WIN);
    wire           sel_dir   = (avs_address == OFS_DIR);
    wire           sel_enr   = (avs_address == OFS_ENC_OUT);
    wire           sel_pm    = (avs_address == OFS_PULSE_MD);
    wire           sel_ctrl  = (avs_address == OFS_CTRL);
    wire           sel_st    = (avs_address == OFS_STATUS);
    wire           crst_hit  = wr_do & sel_ctrl & avs_byteenable[0] & avs_writedata[CTRL_CRST_B];
    logic [31:0]   rd_mux;

    wire [31:0] status_w = ({16'h0000, 16'h0000} | (32'(in_position_flag) << ST_INPOS_B)
                           | (32'(act_r.dir) << ST_DIR_B) | (32'(act_r.pmode) << ST_PMODE_B)
                           | (32'(act_r.encoder_output_pulse_setting) << ST_ENR_LSB));

    always_comb begin
        if (sel_gm)
            rd_mux = {16'h0000, gain_mode_r};
        else if (sel_rsp)
            rd_mux = {16'h0000, resp_r};
        else if (sel_inp)
            rd_mux = {16'h0000, inp_win_r};
        else if (sel_dir)
            rd_mux = {16'h0000, dir_r};
        else if (sel_enr)
            rd_mux = {16'h0000, enr_r};
        else if (sel_pm)
            rd_mux = {16'h0000, pmode_r};
        else if (sel_ctrl)
            rd_mux = 32'(speed_mode_r) << CTRL_SPEED_B;
        else if (sel_st)
            rd_mux = status_w;
        else
            rd_mux = 32'h0000_0000;
    end

    // one wait cycle, then the request completes on the next edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            wait_r  <= ~(req & wait_r);
            if (avs_read & wait_r)
                rdata_r <= rd_mux;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gain_mode_r  <= RST_GAIN_MODE;
            resp_r       <= RST_RESP;
            inp_win_r    <= RST_INP_WIN;
            dir_r        <= RST_DIR;
            enr_r        <= RST_ENC_OUT;
            pmode_r      <= RST_PULSE_MD;
            speed_mode_r <= 1'b0;
        end else if (wr_do) begin
            if (sel_gm)
                gain_mode_r <= be_merge(gain_mode_r, avs_writedata, avs_byteenable);
            if (sel_rsp)
                resp_r <= be_merge(resp_r, avs_writedata, avs_byteenable);
            if (sel_inp)
                inp_win_r <= be_merge(inp_win_r, avs_writedata, avs_byteenable);
            if (sel_dir)
                dir_r <= be_merge(dir_r, avs_writedata, avs_byteenable);
            if (sel_enr)
                enr_r <= be_merge(enr_r, avs_writedata, avs_byteenable);
            if (sel_pm)
                pmode_r <= be_merge(pmode_r, avs_writedata, avs_byteenable);
            if (sel_ctrl && avs_byteenable[0])
                speed_mode_r <= avs_writedata[CTRL_SPEED_B];
        end
    end

    // restart-effective copies; writes to the shadow stay dormant until a controller reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            act_r  <= '{RST_DIR[0], RST_PULSE_MD[0], RST_ENC_OUT};
            crst_r <= 1'b0;
        end else begin
            crst_r <= crst_hit;
            if (crst_r)
                act_r <= '{dir_r[0], pmode_r[0], enr_r};
        end
    end

    // gain mode and update mask
    wire sbs_gain_mode_t gm_w = sbs_gain_mode_t'(gain_mode_r[1:0]);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gain_mode             <= SBS_GM_TUNE1;
            gain_upd              <= upd_decode(SBS_GM_TUNE1);
            tuning_response_level <= RST_RESP;
        end else begin
            gain_mode             <= gm_w;
            gain_upd              <= upd_decode(gm_w);
            // range is the controller's duty, the value passes unchanged
            tuning_response_level <= resp_r;
        end
    end

    // in-position compare against window
    wire [31:0] err_abs = pos_err[31] ? 32'(-pos_err) : 32'(pos_err);
    wire        in_win  = (err_abs <= {16'h0000, inp_win_r});
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            in_position_flag <= 1'b0;
        else
            in_position_flag <= in_win & ~speed_mode_r;
    end

    // address direction to motor rotation
    wire step_ccw = act_r.dir ? addr_dec : addr_inc;
    wire step_cw  = act_r.dir ? addr_inc : addr_dec;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            motor_ccw_step <= 1'b0;
            motor_cw_step  <= 1'b0;
        end else begin
            motor_ccw_step <= step_ccw & ~step_cw;
            motor_cw_step  <= step_cw & ~step_ccw;
        end
    end

    // encoder output: fractional accumulator emits one quadrature edge per overflow (CCW counts) or underflow (CW counts)
    logic [19:0] acc_r;
    logic [1:0]  quad_r;
    // mode 0 scales counts by setting/resolution, mode 1 divides counts by setting
    wire  [19:0] enc_add  = act_r.pmode ? 20'h00001 : {4'h0, act_r.encoder_output_pulse_setting};
    wire  [19:0] enc_mod  = act_r.pmode ? {4'h0, act_r.encoder_output_pulse_setting} : ENC_RES;
    wire  [20:0] sum_up   = {1'b0, acc_r} + {1'b0, enc_add};
    wire         ovf_up   = (sum_up >= {1'b0, enc_mod});
    wire         unf_dn   = (acc_r < enc_add);
    wire  [19:0] acc_up   = ovf_up ? 20'(sum_up - {1'b0, enc_mod}) : sum_up[19:0];
    wire  [19:0] acc_dn   = unf_dn ? 20'(acc_r + enc_mod - enc_add) : 20'(acc_r - enc_add);
    wire         edge_up  = enc_step & enc_ccw & ovf_up;
    wire         edge_dn  = enc_step & ~enc_ccw & unf_dn;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_r  <= 20'h00000;
            quad_r <= 2'b00;
        end else if (crst_r) begin
            acc_r  <= 20'h00000;
        end else if (enc_step) begin
            acc_r  <= enc_ccw ? acc_up : acc_dn;
            // four edges make one A/B cycle, so A runs at a quarter of the edge count
            if (edge_up)
                quad_r <= quad_r + 2'b01;
            else if (edge_dn)
                quad_r <= quad_r - 2'b01;
        end
    end

    // gray output: B leads A turning CCW, A leads B turning CW
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enc_a <= 1'b0;
            enc_b <= 1'b0;
        end else begin
            enc_a <= quad_r[1];
            enc_b <= quad_r[1] ^ quad_r[0];
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign restart_active  = act_r;
endmodule : sbs_basic_setting
`default_nettype wire

// file: common/sbs_pkg.sv
// basic-setting constants, register map and carrier types for the servo block
// assumes a single 200 MHz clock and a word-aligned Avalon-MM register bus
package sbs_pkg;
    localparam int          CLK_MHZ       = 200;
    localparam int          ADDR_W        = 8;
    localparam int          REG_W         = 16;
    // encoder counts per motor revolution
    localparam logic [19:0] ENC_RES       = 20'h40000;
    // register byte addresses
    localparam logic [7:0]  OFS_GAIN_MODE = 8'h00;
    localparam logic [7:0]  OFS_RESP      = 8'h04;
    localparam logic [7:0]  OFS_INP_WIN   = 8'h08;
    localparam logic [7:0]  OFS_DIR       = 8'h0C;
    localparam logic [7:0]  OFS_ENC_OUT   = 8'h10;
    localparam logic [7:0]  OFS_PULSE_MD  = 8'h14;
    localparam logic [7:0]  OFS_CTRL      = 8'h18;
    localparam logic [7:0]  OFS_STATUS    = 8'h1C;
    // reset values
    localparam logic [15:0] RST_GAIN_MODE = 16'h0001;
    localparam logic [15:0] RST_RESP      = 16'h000C;
    localparam logic [15:0] RST_INP_WIN   = 16'h0064;
    localparam logic [15:0] RST_DIR       = 16'h0000;
    localparam logic [15:0] RST_ENC_OUT   = 16'h0FA0;
    localparam logic [15:0] RST_PULSE_MD  = 16'h0000;
    // field positions
    localparam int          CTRL_SPEED_B  = 0;
    localparam int          CTRL_CRST_B   = 1;
    localparam int          ST_INPOS_B    = 0;
    localparam int          ST_DIR_B      = 1;
    localparam int          ST_PMODE_B    = 2;
    localparam int          ST_ENR_LSB    = 16;

    typedef enum logic [1:0] {
        SBS_GM_INTERP = 2'b00,
        SBS_GM_TUNE1  = 2'b01,
        SBS_GM_TUNE2  = 2'b10,
        SBS_GM_MANUAL = 2'b11
    } sbs_gain_mode_t;

    // which gain settings the tuning engine may overwrite
    typedef struct packed {
        logic inertia;
        logic model;
        logic position;
        logic speed;
        logic integral;
    } sbs_gain_upd_t;

    // settings that only take effect at restart
    typedef struct packed {
        logic        dir;
        logic        pmode;
        logic [15:0] encoder_output_pulse_setting;
    } sbs_restart_t;
endpackage : sbs_pkg

// file: sim/sbs_enc_model.sv
// motor side: issues encoder counts, decodes the A/B pair back into a count
// assumes the block's clock; one count goes out every 64 cycles
`timescale 1ns/1ps
`default_nettype none
module sbs_enc_model (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               arst_n,
    // bench control
    input  wire logic               start,
    input  wire logic        [15:0] n_steps,
    input  wire logic               ccw,
    output logic                    busy,
    output logic signed      [15:0] count,
    // block side
    output logic                    enc_step,
    output logic                    enc_ccw,
    input  wire logic               enc_a,
    input  wire logic               enc_b
);
    logic [15:0] left_r;
    logic [5:0]  gap_r;
    logic [1:0]  ph_r;
    wire  [1:0]  ph  = {enc_a, enc_a ^ enc_b};
    wire  [1:0]  dph = ph - ph_r;
    assign busy = left_r != 16'h0;
    // slow counts keep even a 1:1 setting under the output rate ceiling
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {left_r, gap_r, ph_r, enc_step, enc_ccw} <= '0;
            count <= 16'sh0;
        end else begin
            gap_r <= gap_r + 6'h1;
            ph_r <= ph;
            enc_ccw <= ccw;
            enc_step <= busy && gap_r == 6'h0;
            if (start) left_r <= n_steps;
            else if (busy && gap_r == 6'h0) left_r <= left_r - 16'h1;
            if (dph == 2'h1) count <= count + 16'sh1;
            else if (dph == 2'h3) count <= count - 16'sh1;
        end
    end
endmodule : sbs_enc_model
`default_nettype wire

// file: sim/sbs_basic_setting_assertions.sv
// checker: bus wait timing, gain masks, step mapping, A/B output
// assumes it is bound to sbs_basic_setting and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module sbs_checker (
    input wire logic                  clk,
    input wire logic                  arst_n,
    input wire logic                  avs_read,
    input wire logic                  avs_write,
    input wire logic                  avs_waitrequest,
    input wire logic signed [31:0]    pos_err,
    input wire logic                  addr_inc,
    input wire logic                  addr_dec,
    input wire logic                  motor_ccw_step,
    input wire logic                  motor_cw_step,
    input wire logic                  in_position_flag,
    input wire logic                  enc_step,
    input wire logic                  enc_a,
    input wire logic                  enc_b,
    input wire sbs_pkg::sbs_gain_mode_t gain_mode,
    input wire sbs_pkg::sbs_gain_upd_t  gain_upd,
    input wire sbs_pkg::sbs_restart_t   restart_active
);
    import sbs_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not answered after one wait cycle");
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_gain_mask: assert property (gain_upd == (gain_mode == SBS_GM_INTERP ? 5'h17 :
        gain_mode == SBS_GM_TUNE1 ? 5'h1F : gain_mode == SBS_GM_TUNE2 ? 5'h0F : 5'h00))
        else $error("gain update mask does not match mode");
    chk_step_inc: assert property (addr_inc && !addr_dec |=>
        motor_ccw_step == !$past(restart_active.dir) && motor_cw_step == $past(restart_active.dir))
        else $error("wrong rotation for rising address");
    chk_step_dec: assert property (addr_dec && !addr_inc |=>
        motor_cw_step == !$past(restart_active.dir) && motor_ccw_step == $past(restart_active.dir))
        else $error("wrong rotation for falling address");
    chk_no_step: assert property (addr_inc == addr_dec |=> !motor_ccw_step && !motor_cw_step)
        else $error("step without a single address change");
    chk_inpos_far: assert property (pos_err > 65535 || pos_err < -65535 |=> !in_position_flag)
        else $error("in position beyond the widest window");
    chk_quad_gray: assert property (!($changed(enc_a) && $changed(enc_b)))
        else $error("both phases changed together");
    chk_enc_cause: assert property ($changed(enc_a) || $changed(enc_b) |-> $past(enc_step, 2))
        else $error("phase edge without an encoder count");
endmodule : sbs_checker
bind sbs_basic_setting sbs_checker i_sbs_checker (.clk, .arst_n, .avs_read, .avs_write, .avs_waitrequest,
    .pos_err, .addr_inc, .addr_dec, .motor_ccw_step, .motor_cw_step, .in_position_flag, .enc_step,
    .enc_a, .enc_b, .gain_mode, .gain_upd, .restart_active);
`default_nettype wire

// file: sim/sbs_basic_setting_test.sv
// self-checking bench for the basic-setting block
// assumes sbs_enc_model on the motor side and the bound checker
`timescale 1ns/1ps
`default_nettype none
module sbs_basic_setting_test;
    import sbs_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, addr_inc = 1'b0, addr_dec = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic signed [31:0] pos_err = 32'sh0;
    logic avs_waitrequest, motor_ccw_step, motor_cw_step, in_position_flag, enc_step, enc_ccw, enc_a, enc_b;
    logic start = 1'b0, ccw = 1'b1, busy;
    logic [15:0] n_steps = 16'h0, resp;
    logic signed [15:0] count;
    sbs_gain_mode_t gain_mode;
    sbs_gain_upd_t gain_upd;
    sbs_restart_t restart_active;
    logic [4:0] upd_tbl [4] = '{5'h17, 5'h1F, 5'h0F, 5'h00};
    logic [31:0] exp_q [$];
    int n_mismatch = 0, comparisons = 0, cycles = 0, win;
    always #2.5 clk = ~clk;
    sbs_basic_setting i_sbs_basic_setting (.clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'h3), .avs_readdata, .avs_waitrequest, .pos_err, .addr_inc, .addr_dec, .motor_ccw_step,
        .motor_cw_step, .in_position_flag, .enc_step, .enc_ccw, .enc_a, .enc_b, .gain_mode, .gain_upd,
        .tuning_response_level(resp), .restart_active);
    sbs_enc_model i_sbs_enc_model (.clk, .arst_n, .start, .n_steps, .ccw, .busy, .count, .enc_step, .enc_ccw,
        .enc_a, .enc_b);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // read expectations go to the queue; the monitor below pairs them
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        if (!w) exp_q.push_back(d);
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : acc
    always @(posedge clk) if (avs_read && avs_waitrequest === 1'b0) chk(avs_readdata, exp_q.pop_front());
    task automatic step(input logic inc, input logic dec, input logic [1:0] exp);
        @(posedge clk);
        addr_inc <= inc;
        addr_dec <= dec;
        @(posedge clk);
        addr_inc <= 1'b0;
        addr_dec <= 1'b0;
        #1 chk({motor_ccw_step, motor_cw_step}, exp);
    endtask : step
    task automatic inpos(input logic signed [31:0] e, input logic exp);
        @(posedge clk);
        pos_err <= e;
        repeat (2) @(posedge clk);
        #1 chk(in_position_flag, exp);
    endtask : inpos
    task automatic enc(input int n, input logic dir, input int exp);
        @(posedge clk);
        n_steps <= 16'(n);
        ccw <= dir;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        while (busy) @(posedge clk);
        repeat (4) @(posedge clk);
        #1 chk(32'(count), 32'(exp));
    endtask : enc
    always @(posedge clk) begin
        cycles++;
        if (cycles == 45000) begin
            n_mismatch++;
            $display("MISMATCH %0t timeout", $time);
            end_sim();
        end
    end
    initial begin
        void'($urandom(32'hCD2F));
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        acc(0, OFS_GAIN_MODE, 32'h1);
        acc(0, OFS_RESP, 32'hC);
        acc(0, OFS_INP_WIN, 32'h64);
        acc(0, OFS_DIR, 32'h0);
        acc(0, OFS_ENC_OUT, 32'hFA0);
        acc(0, OFS_STATUS, 32'h0FA00001);
        acc(0, 8'h20, 32'h0);
        for (int m = 0; m < 4; m++) begin
            acc(1, OFS_GAIN_MODE, 32'(m));
            repeat (2) @(posedge clk);
            #1 chk(gain_mode, 32'(m));
            chk(gain_upd, upd_tbl[m]);
        end
        acc(1, OFS_RESP, 32'h20);
        // the response copy is registered, so it follows the write one edge later
        @(posedge clk);
        #1 chk(resp, 32'h20);
        win = $urandom_range(1000, 1);
        acc(1, OFS_INP_WIN, 32'(win));
        inpos(win, 1'b1);
        inpos(-win, 1'b1);
        inpos(win + 1, 1'b0);
        inpos(70000, 1'b0);
        acc(1, OFS_CTRL, 32'h1);
        inpos(0, 1'b0);
        acc(1, OFS_CTRL, 32'h0);
        inpos(0, 1'b1);
        acc(1, OFS_DIR, 32'h1);
        step(1'b1, 1'b0, 2'b10);
        acc(1, OFS_CTRL, 32'h2);
        // active settings switch one edge after the controller reset completes
        repeat (2) @(posedge clk);
        step(1'b1, 1'b0, 2'b01);
        step(1'b0, 1'b1, 2'b10);
        step(1'b1, 1'b1, 2'b00);
        acc(0, OFS_STATUS, 32'h0FA00003);
        acc(1, OFS_DIR, 32'h0);
        acc(1, OFS_ENC_OUT, 32'h1);
        acc(1, OFS_PULSE_MD, 32'h1);
        acc(1, OFS_CTRL, 32'h2);
        enc(16, 1'b1, 16);
        enc(8, 1'b0, 8);
        acc(1, OFS_ENC_OUT, 32'h8);
        acc(1, OFS_CTRL, 32'h2);
        enc(64, 1'b1, 16);
        acc(1, OFS_ENC_OUT, 32'hFFFF);
        acc(1, OFS_PULSE_MD, 32'h0);
        acc(1, OFS_CTRL, 32'h2);
        enc(400, 1'b1, 115);
        end_sim();
    end
endmodule : sbs_basic_setting_test
`default_nettype wire
